// file: pkg/sfce_pkg.sv
package sfce_pkg;

  // ****************************************
  // Clock and protection
  // ****************************************
  localparam int         CLK_PERIOD_NS = 5;
  localparam logic [4:0] PROT_SHIFT    = 5'h0f;  // Smallest protected span is 2**(15+1)

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_DUAL_READ = 8'h3b;
  localparam logic [7:0] OP_MFR_DEV   = 8'h90;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] OP_STD_ID    = 8'h9f;
  localparam logic [7:0] OP_SLEEP     = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID   = 8'hab;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECT_CLR  = 8'h20;
  localparam logic [7:0] OP_BLK_CLR   = 8'h52;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;

  // ****************************************
  // Frame byte counts and fixed values
  // ****************************************
  localparam logic [4:0]  ADDR_LAST    = 5'h02;  // Index of last address byte
  localparam logic [4:0]  DUAL_DUMMY   = 5'h01;
  localparam logic [4:0]  UID_DUMMY    = 5'h04;
  localparam logic [4:0]  WAKE_DUMMY   = 5'h03;
  localparam logic [4:0]  STD_ID_MFR   = 5'h00;
  localparam logic [4:0]  STD_ID_TYPE  = 5'h01;
  localparam logic [4:0]  STD_ID_CAP   = 5'h02;
  localparam logic [23:0] MFR_DEV_SWAP = 24'h000001;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_DATA, ST_END, ST_SKIP} sfce_state_t;
  typedef enum logic [2:0] {TM_NONE, TM_PROG, TM_SECT, TM_BLK, TM_SLEEP, TM_WAKE} sfce_timer_t;

  typedef struct packed {
    logic        rd;
    logic        load;
    logic        latch_clr;
    logic        prog;
    logic        sect_clr;
    logic        blk_clr;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfce_mem_req_t;

endpackage

// file: verilog/sfce_engine.sv
`timescale 1ns/1ps
// What this block does
// - Dual read: take opcode, three address bytes, one dummy byte, return two bits/clock.
// - Dual read starts anywhere and steps the address after every output byte.
// - Manufacturer/device ID with address zero returns manufacturer byte, then device byte.
// - Manufacturer/device ID with address one returns device byte first.
// - Unique ID: four dummy bytes, then the 128-bit identifier on falling edges.
// - Standard ID returns manufacturer, memory type and capacity bytes on falling edges.
// - Standard ID arriving during program or erase is not decoded; cycle continues.
// - Chip select rising ends any readout at any bit and returns to standby.
// - Sleep opcode counts only with chip select rising after exactly eight bits.
// - In deep sleep only the wake opcode is recognised; all others ignored.
// - Wake opcode then chip select high for wake time before other commands.
// - Wake opcode plus three dummies streams device ID repeatedly, MSB first.
// - Wake with ID read needs the longer wake-with-ID time before resuming.
// - Wake/ID opcode is ignored while write busy, leaving the cycle untouched.
// - Page program needs write latch, opcode, address and at least one data byte.
// - Program data past the page end wraps to the page start.
// - Only the last 256 bytes are kept; unsent bytes stay unchanged.
// - Program starts at a byte boundary; busy during cycle, latch cleared before end.
// - Program or erase aimed at a protected range is refused.
// - Sector erase: latch set, boundary after address, self-timed with busy set.
// - Block erase behaves like sector erase over a 32 KB block.
// - Write enable opcode sets the write latch flag.
// - Dual output: first line carries even bits, second line odd bits.
module sfce_engine #(
  parameter int          MEM_AW         = 19,
  parameter int          PROG_TIME_NS   = 1000000,
  parameter int          SECT_TIME_NS   = 100000000,
  parameter int          BLK_TIME_NS    = 500000000,
  parameter int          SLEEP_ENTRY_NS = 3000,
  parameter int          WAKE_NS        = 3000,
  parameter int          WAKE_ID_NS     = 5000,
  parameter logic [7:0]  MFR_ID         = 8'h5a,   // Arbitrary value
  parameter logic [7:0]  DEV_ID         = 8'h12,   // Arbitrary value
  parameter logic [7:0]  MEM_TYPE       = 8'h40,   // Arbitrary value
  parameter logic [7:0]  MEM_CAP        = 8'h13,   // Arbitrary value
  parameter logic [127:0] UNIQUE_ID     = 128'h0123456789abcdeffedcba9876543210  // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_IN,
  input  wire logic                  CE_IN,
  // Serial link
  input  wire logic                  CS_N_IN,
  input  wire logic                  SCLK_IN,
  input  wire logic                  IO0_IN,
  output logic                       IO0_OUT,
  output logic                       IO0_OE_N_OUT,
  output logic                       IO1_OUT,
  output logic                       IO1_OE_N_OUT,
  // Protection and status
  input  wire logic [2:0]            PROTECT_RANGE_IN,
  output logic                       WRITE_BUSY_FLAG_OUT,
  output logic                       WRITE_LATCH_FLAG_OUT,
  output logic                       DEEP_SLEEP_OUT,
  // Memory array
  output sfce_pkg::sfce_mem_req_t    MEM_REQ_OUT,
  input  wire logic [7:0]            MEM_RDATA_IN
);

  localparam int P = sfce_pkg::CLK_PERIOD_NS;
  // Self-timed cycles round up; wake and entry must finish in time, so they round down
  localparam int PROG_CYC  = (PROG_TIME_NS + P - 1) / P;
  localparam int SECT_CYC  = (SECT_TIME_NS + P - 1) / P;
  localparam int BLK_CYC   = (BLK_TIME_NS + P - 1) / P;
  localparam int SLEEP_CYC = (SLEEP_ENTRY_NS / P < 1) ? 1 : SLEEP_ENTRY_NS / P;
  localparam int WAKE_CYC  = (WAKE_NS / P < 1) ? 1 : WAKE_NS / P;
  localparam int WAKEI_CYC = (WAKE_ID_NS / P < 1) ? 1 : WAKE_ID_NS / P;

  if (MEM_AW < 16 || MEM_AW > 24) begin : g_bad_aw
    $error("MEM_AW must lie in 16..24");
  end
  if (PROG_TIME_NS < 1 || SECT_TIME_NS < 1 || BLK_TIME_NS < 1) begin : g_bad_time
    $error("Cycle times must be positive");
  end

  logic [2:0]            cs_s;
  logic [2:0]            clk_s;
  logic [1:0]            si_s;
  sfce_pkg::sfce_state_t state;
  sfce_pkg::sfce_timer_t tm_op;
  logic [31:0]           tm_cnt;
  logic [7:0]            cmd;
  logic [6:0]            sr_in;
  logic [2:0]            bit_idx;
  logic [4:0]            byte_cnt;
  logic [23:0]           addr;
  logic                  got_data;
  logic                  prep_req;
  logic [7:0]            nxt_byte;
  logic [7:0]            out_sr;
  logic [2:0]            sub;
  logic                  rd_wait;
  logic                  write_latch_flag;
  logic                  write_busy_flag;
  logic                  sleep;
  sfce_pkg::sfce_mem_req_t mem_req;

  // ****************************************
  // Link edge detection
  // ****************************************
  // Stage 0 feeds stage 1 only; edges compare stages 1 and 2
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cs_s  <= 3'h7;
      clk_s <= 3'h0;
      si_s  <= 2'h0;
    end else if (CE_IN) begin
      cs_s  <= {cs_s[1:0], CS_N_IN};
      clk_s <= {clk_s[1:0], SCLK_IN};
      si_s  <= {si_s[0], IO0_IN};
    end
  end

  wire       cs_low    = ~cs_s[1];
  wire       cs_fall   = ~cs_s[1] & cs_s[2];
  wire       cs_rise   = cs_s[1] & ~cs_s[2];
  wire       sck_rise  = clk_s[1] & ~clk_s[2] & cs_low;
  wire       sck_fall  = ~clk_s[1] & clk_s[2] & cs_low;
  wire [7:0] in_byte   = {sr_in, si_s[1]};
  wire       byte_done = sck_rise && (bit_idx == 3'h7);
  wire       dual      = (cmd == sfce_pkg::OP_DUAL_READ);
  wire       at_bound  = (bit_idx == 3'h0);

  // ****************************************
  // Opcode decode
  // ****************************************
  wire to_addr  = in_byte inside {sfce_pkg::OP_DUAL_READ, sfce_pkg::OP_MFR_DEV, sfce_pkg::OP_PAGE_PROG,
                                  sfce_pkg::OP_SECT_CLR, sfce_pkg::OP_BLK_CLR};
  wire to_dummy = in_byte inside {sfce_pkg::OP_UNIQUE_ID, sfce_pkg::OP_WAKE_ID};
  wire to_out   = in_byte inside {sfce_pkg::OP_STD_ID, sfce_pkg::OP_STATUS_RD};
  wire to_end   = in_byte inside {sfce_pkg::OP_WR_EN, sfce_pkg::OP_WR_DIS, sfce_pkg::OP_SLEEP};
  wire timed    = (tm_op != sfce_pkg::TM_NONE);
  // Busy admits status read only; wake or entry wait admits nothing; sleep admits wake
  wire op_ok    = write_busy_flag ? (in_byte == sfce_pkg::OP_STATUS_RD) :
                  timed ? 1'b0 :
                  sleep ? (in_byte == sfce_pkg::OP_WAKE_ID) :
                  (to_addr | to_dummy | to_out | to_end);
  wire [4:0] dummy_n = (cmd == sfce_pkg::OP_UNIQUE_ID) ? sfce_pkg::UID_DUMMY :
                       (cmd == sfce_pkg::OP_WAKE_ID) ? sfce_pkg::WAKE_DUMMY : sfce_pkg::DUAL_DUMMY;

  // Protected span covers the top of memory, doubling per step of the range bits
  wire [MEM_AW-1:0] pmask = {MEM_AW{1'b1}} << (sfce_pkg::PROT_SHIFT + {2'h0, PROTECT_RANGE_IN});
  wire prot = (|PROTECT_RANGE_IN) && ((addr[MEM_AW-1:0] & pmask) == pmask);

  // ****************************************
  // Output byte source
  // ****************************************
  wire [7:0] status_byte = {3'h0, PROTECT_RANGE_IN, write_latch_flag, write_busy_flag};
  wire       mfr_second  = byte_cnt[0] ^ (addr == sfce_pkg::MFR_DEV_SWAP);
  wire [7:0] std_byte    = (byte_cnt == sfce_pkg::STD_ID_MFR) ? MFR_ID :
                           (byte_cnt == sfce_pkg::STD_ID_TYPE) ? MEM_TYPE :
                           (byte_cnt == sfce_pkg::STD_ID_CAP) ? MEM_CAP : 8'h00;
  wire [7:0] src_byte    = (cmd == sfce_pkg::OP_MFR_DEV) ? (mfr_second ? DEV_ID : MFR_ID) :
                           (cmd == sfce_pkg::OP_UNIQUE_ID) ? UNIQUE_ID[{~byte_cnt[3:0], 3'h0} +: 8] :
                           (cmd == sfce_pkg::OP_STD_ID) ? std_byte :
                           (cmd == sfce_pkg::OP_WAKE_ID) ? DEV_ID :
                           status_byte;

  // ****************************************
  // Frame end outcomes
  // ****************************************
  wire end_cmd     = (state == sfce_pkg::ST_END) && at_bound;
  wire end_wr_en   = end_cmd && (cmd == sfce_pkg::OP_WR_EN);
  wire end_wr_dis  = end_cmd && (cmd == sfce_pkg::OP_WR_DIS);
  wire end_sleep   = end_cmd && (cmd == sfce_pkg::OP_SLEEP);
  wire end_prog    = (state == sfce_pkg::ST_DATA) && got_data && at_bound && write_latch_flag && !prot;
  wire end_sect    = end_cmd && (cmd == sfce_pkg::OP_SECT_CLR) && write_latch_flag && !prot;
  wire end_blk     = end_cmd && (cmd == sfce_pkg::OP_BLK_CLR) && write_latch_flag && !prot;
  wire wake_cmd    = sleep && (cmd == sfce_pkg::OP_WAKE_ID);
  wire end_wake    = wake_cmd && (state == sfce_pkg::ST_DUMMY) && (byte_cnt == 5'h00) && at_bound;
  wire end_wake_id = wake_cmd && (state == sfce_pkg::ST_OUT);
  wire end_write   = end_prog | end_sect | end_blk;

  wire sfce_pkg::sfce_timer_t next_op =
    end_prog ? sfce_pkg::TM_PROG : end_sect ? sfce_pkg::TM_SECT : end_blk ? sfce_pkg::TM_BLK :
    end_sleep ? sfce_pkg::TM_SLEEP : (end_wake | end_wake_id) ? sfce_pkg::TM_WAKE : sfce_pkg::TM_NONE;
  wire [31:0] next_cnt =
    end_prog ? 32'(PROG_CYC) : end_sect ? 32'(SECT_CYC) : end_blk ? 32'(BLK_CYC) :
    end_sleep ? 32'(SLEEP_CYC) : end_wake_id ? 32'(WAKEI_CYC) : 32'(WAKE_CYC);

  // ****************************************
  // Frame decoder
  // ****************************************
  // Bytes are acted on at the rising edge that completes them
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state    <= sfce_pkg::ST_IDLE;
      cmd      <= 8'h00;
      sr_in    <= 7'h00;
      bit_idx  <= 3'h0;
      byte_cnt <= 5'h00;
      addr     <= 24'h000000;
      got_data <= 1'b0;
      prep_req <= 1'b0;
    end else if (CE_IN) begin
      prep_req <= 1'b0;
      if (cs_fall) begin
        state    <= sfce_pkg::ST_CMD;
        bit_idx  <= 3'h0;
        got_data <= 1'b0;
      end else if (!cs_low) begin
        state <= sfce_pkg::ST_IDLE;
      end else begin
        if (sck_rise) begin
          bit_idx <= bit_idx + 3'h1;
          sr_in   <= in_byte[6:0];
        end
        if (byte_done) begin
          case (state)
            sfce_pkg::ST_CMD: begin
              cmd      <= in_byte;
              byte_cnt <= 5'h00;
              prep_req <= op_ok && to_out;
              state    <= !op_ok ? sfce_pkg::ST_SKIP : to_addr ? sfce_pkg::ST_ADDR :
                          to_dummy ? sfce_pkg::ST_DUMMY : to_out ? sfce_pkg::ST_OUT : sfce_pkg::ST_END;
            end
            sfce_pkg::ST_ADDR: begin
              addr     <= {addr[15:0], in_byte};
              byte_cnt <= byte_cnt + 5'h01;
              if (byte_cnt == sfce_pkg::ADDR_LAST) begin
                byte_cnt <= 5'h00;
                prep_req <= (cmd == sfce_pkg::OP_MFR_DEV);
                state    <= dual ? sfce_pkg::ST_DUMMY : (cmd == sfce_pkg::OP_MFR_DEV) ? sfce_pkg::ST_OUT :
                            (cmd == sfce_pkg::OP_PAGE_PROG) ? sfce_pkg::ST_DATA : sfce_pkg::ST_END;
              end
            end
            sfce_pkg::ST_DUMMY: begin
              // Input value is unused here, the byte only counts clocks
              byte_cnt <= byte_cnt + 5'h01;
              if (byte_cnt == dummy_n - 5'h01) begin
                byte_cnt <= 5'h00;
                prep_req <= 1'b1;
                state    <= sfce_pkg::ST_OUT;
              end
            end
            sfce_pkg::ST_DATA: begin
              addr[7:0] <= addr[7:0] + 8'h01;
              got_data  <= 1'b1;
            end
            sfce_pkg::ST_END: state <= sfce_pkg::ST_SKIP;
            default: state <= state;
          endcase
        end
        if (prep_req) begin
          byte_cnt <= byte_cnt + 5'h01;
          if (dual) begin
            addr <= addr + 24'h000001;
          end
        end
        if (sck_fall && (state == sfce_pkg::ST_OUT) && (sub == 3'h0)) begin
          prep_req <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Output shifter
  // ****************************************
  // Next byte is staged a full byte ahead so a slow array read never starves the line
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      nxt_byte     <= 8'h00;
      out_sr       <= 8'h00;
      sub          <= 3'h0;
      rd_wait      <= 1'b0;
      IO0_OUT      <= 1'b0;
      IO1_OUT      <= 1'b0;
      IO0_OE_N_OUT <= 1'b1;
      IO1_OE_N_OUT <= 1'b1;
    end else if (CE_IN) begin
      rd_wait <= mem_req.rd;
      if (rd_wait) begin
        nxt_byte <= MEM_RDATA_IN;
      end else if (prep_req && !dual) begin
        nxt_byte <= src_byte;
      end
      if (!cs_low) begin
        sub          <= 3'h0;
        IO0_OE_N_OUT <= 1'b1;
        IO1_OE_N_OUT <= 1'b1;
      end else if (sck_fall && (state == sfce_pkg::ST_OUT)) begin
        IO1_OUT      <= (sub == 3'h0) ? nxt_byte[7] : out_sr[7];
        IO0_OUT      <= (sub == 3'h0) ? nxt_byte[6] : out_sr[6];
        out_sr       <= dual ? {((sub == 3'h0) ? nxt_byte[5:0] : out_sr[5:0]), 2'h0} :
                               {((sub == 3'h0) ? nxt_byte[6:0] : out_sr[6:0]), 1'h0};
        sub          <= (sub == (dual ? 3'h3 : 3'h7)) ? 3'h0 : sub + 3'h1;
        IO1_OE_N_OUT <= 1'b0;
        IO0_OE_N_OUT <= !dual;
      end
    end
  end

  // ****************************************
  // Timed cycles and flags
  // ****************************************
  // Latch clears as the write cycle starts, well before busy falls
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tm_op  <= sfce_pkg::TM_NONE;
      tm_cnt <= 32'h0;
      write_latch_flag    <= 1'b0;
      write_busy_flag    <= 1'b0;
      sleep  <= 1'b0;
    end else if (CE_IN) begin
      if (timed) begin
        tm_cnt <= tm_cnt - 32'h1;
        if (tm_cnt == 32'h1) begin
          tm_op <= sfce_pkg::TM_NONE;
          write_busy_flag   <= 1'b0;
          sleep <= (tm_op == sfce_pkg::TM_SLEEP);
        end
      end
      if (cs_rise && (next_op != sfce_pkg::TM_NONE)) begin
        tm_op  <= next_op;
        tm_cnt <= next_cnt;
        write_busy_flag    <= end_write;
      end
      if (cs_rise && (end_write || end_wr_dis)) begin
        write_latch_flag <= 1'b0;
      end else if (cs_rise && end_wr_en) begin
        write_latch_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // Memory array requests
  // ****************************************
  // Loads land in the page latch by column, so later bytes overwrite earlier ones
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mem_req <= '0;
    end else if (CE_IN) begin
      mem_req.rd        <= prep_req && dual;
      mem_req.load      <= byte_done && (state == sfce_pkg::ST_DATA);
      mem_req.latch_clr <= byte_done && (state == sfce_pkg::ST_ADDR) && (byte_cnt == sfce_pkg::ADDR_LAST) &&
                           (cmd == sfce_pkg::OP_PAGE_PROG);
      mem_req.prog      <= cs_rise && end_prog;
      mem_req.sect_clr  <= cs_rise && end_sect;
      mem_req.blk_clr   <= cs_rise && end_blk;
      mem_req.addr      <= addr;
      mem_req.data      <= in_byte;
    end
  end

  assign MEM_REQ_OUT          = mem_req;
  assign WRITE_BUSY_FLAG_OUT  = write_busy_flag;
  assign WRITE_LATCH_FLAG_OUT = write_latch_flag;
  assign DEEP_SLEEP_OUT       = sleep;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence dual_prep_s;
    CE_IN && prep_req && dual;
  endsequence
  sequence sleep_go_s;
    CE_IN && cs_rise && end_sleep;
  endsequence

  rd_request_a: assert property (dual_prep_s |=> mem_req.rd && mem_req.addr == $past(addr))
    else $error("Dual read request address wrong");
  addr_step_a: assert property (dual_prep_s |=> addr == $past(addr) + 24'h000001)
    else $error("Dual read address did not step");
  dual_lines_a: assert property (CE_IN && sck_fall && state == sfce_pkg::ST_OUT && dual && sub == 3'h0
    |=> IO1_OUT == $past(nxt_byte[7]) && IO0_OUT == $past(nxt_byte[6]) && !IO0_OE_N_OUT)
    else $error("Dual output bit order wrong");
  mfr_order_a: assert property (CE_IN && prep_req && cmd == sfce_pkg::OP_MFR_DEV && byte_cnt == 5'h00
    |=> nxt_byte == (($past(addr) == sfce_pkg::MFR_DEV_SWAP) ? DEV_ID : MFR_ID))
    else $error("Manufacturer/device order wrong");
  std_first_a: assert property (CE_IN && prep_req && cmd == sfce_pkg::OP_STD_ID && byte_cnt == 5'h00
    |=> nxt_byte == MFR_ID)
    else $error("Standard ID first byte wrong");
  busy_refuse_a: assert property (CE_IN && byte_done && state == sfce_pkg::ST_CMD && write_busy_flag
    && in_byte != sfce_pkg::OP_STATUS_RD |=> state == sfce_pkg::ST_SKIP && write_busy_flag)
    else $error("Opcode decoded while busy");
  sleep_filter_a: assert property (CE_IN && byte_done && state == sfce_pkg::ST_CMD && sleep
    && in_byte != sfce_pkg::OP_WAKE_ID |=> state == sfce_pkg::ST_SKIP)
    else $error("Opcode decoded in deep sleep");
  cs_end_a: assert property (CE_IN && cs_rise |=> state == sfce_pkg::ST_IDLE ##1 IO1_OE_N_OUT)
    else $error("Readout not ended by chip select");
  sleep_entry_a: assert property (sleep_go_s |=> tm_op == sfce_pkg::TM_SLEEP && !sleep)
    else $error("Sleep entry not started");
  prog_start_a: assert property (CE_IN && cs_rise && end_prog
    |=> WRITE_BUSY_FLAG_OUT && !WRITE_LATCH_FLAG_OUT && mem_req.prog)
    else $error("Program start flags wrong");
  refuse_keep_a: assert property (CE_IN && cs_rise && state == sfce_pkg::ST_DATA && prot
    |=> WRITE_LATCH_FLAG_OUT == $past(write_latch_flag) && !mem_req.prog && !WRITE_BUSY_FLAG_OUT == !$past(write_busy_flag))
    else $error("Refused program changed state");
  page_wrap_a: assert property (CE_IN && byte_done && state == sfce_pkg::ST_DATA
    |=> mem_req.load && addr[23:8] == $past(addr[23:8]) && addr[7:0] == $past(addr[7:0]) + 8'h01)
    else $error("Page column did not wrap in page");

endmodule // sfce_engine

// file: verif/sfce_host_model.sv
`timescale 1ns/1ps
// ****
// Host side of the serial link
// ****
module sfce_host_model (
  // Clock and lines
  input  wire logic clk_in,
  input  wire logic io0_in,
  input  wire logic io1_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  // Idle: deselected, link clock parked low
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // Wait n system clocks, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Bit set while low, sampled late in the high phase so the 3-cycle output lag has settled
  task automatic xfer(input logic [7:0] tx, input bit dual, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      sclk_out = 1'b0;
      mosi_out = tx[7 - i];
      tick(12);
      sclk_out = 1'b1;
      tick(13);
      rx = dual ? {rx[5:0], io1_in, io0_in} : {rx[6:0], io1_in};
    end
  endtask
  // Frames end on whole bytes only; the clock stands still between frames
  task automatic open_f();
    cs_n_out = 1'b0;
    tick(4);
  endtask
  task automatic close_f();
    sclk_out = 1'b0;
    mosi_out = ~mosi_out;
    tick(12);
    cs_n_out = 1'b1;
    tick(8);
  endtask
endmodule // sfce_host_model

// file: verif/test_spi_flash_command_engine.sv
`timescale 1ns/1ps
// ****
// Bench top
// ****
module test_spi_flash_command_engine;
  localparam logic [7:0]   MFR = 8'hc3;  // Arbitrary value
  localparam logic [7:0]   DEV = 8'h27;  // Arbitrary value
  localparam logic [7:0]   TYP = 8'h61;  // Arbitrary value
  localparam logic [7:0]   CAP = 8'h0e;  // Arbitrary value
  localparam logic [127:0] UID = 128'hd1e2f3a4b5c6d7e8f9a0b1c2d3e4f5a6;  // Arbitrary value
  // Short self-timed cycles keep the run brief
  localparam int           PP_NS = 2000, SE_NS = 2000, BE_NS = 20000, SL_NS = 500, WK_NS = 500, WI_NS = 750;
  logic                    CLK_IN = 1'b0;
  logic                    RST_IN = 1'b1;
  logic                    ce = 1'b1;
  logic [2:0]              prot = 3'h0;
  logic [7:0]              mem_q = 8'h00;
  logic [23:0]             last_load = 24'h000000;
  logic                    seen_oe = 1'b0;
  logic [7:0]              rx [0:7];
  int                      n_errors = 0;
  int                      check_count = 0;
  wire logic               cs_n, sclk, mosi, io0_o, io0_oe_n, io1_o, io1_oe_n, busy, latch, sleep;
  sfce_pkg::sfce_mem_req_t req;
  // Wire levels: a released IO1 shows the inverse of its last value
  wire logic               io0 = io0_oe_n ? mosi : io0_o;
  wire logic               io1 = io1_o ^ io1_oe_n;
  always #2.5 CLK_IN = ~CLK_IN;
  // Array model answers the cycle after a read request; also log loads and output enables
  always @(posedge CLK_IN) begin
    if (req.rd) mem_q <= req.addr[7:0] ^ 8'h3c;
    if (req.load) last_load <= req.addr;
    if (!io1_oe_n) seen_oe <= 1'b1;
  end
  sfce_host_model host_u (.clk_in(CLK_IN), .io0_in(io0), .io1_in(io1), .cs_n_out(cs_n), .sclk_out(sclk),
    .mosi_out(mosi));
  sfce_engine #(.PROG_TIME_NS(PP_NS), .SECT_TIME_NS(SE_NS), .BLK_TIME_NS(BE_NS), .SLEEP_ENTRY_NS(SL_NS),
    .WAKE_NS(WK_NS), .WAKE_ID_NS(WI_NS), .MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .MEM_CAP(CAP),
    .UNIQUE_ID(UID)) dut_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(ce), .CS_N_IN(cs_n), .SCLK_IN(sclk),
    .IO0_IN(io0), .IO0_OUT(io0_o), .IO0_OE_N_OUT(io0_oe_n), .IO1_OUT(io1_o), .IO1_OE_N_OUT(io1_oe_n),
    .PROTECT_RANGE_IN(prot), .WRITE_BUSY_FLAG_OUT(busy), .WRITE_LATCH_FLAG_OUT(latch),
    .DEEP_SLEEP_OUT(sleep), .MEM_REQ_OUT(req), .MEM_RDATA_IN(mem_q));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One frame: nh header bytes from the top of hdr, then nr bytes read back
  task automatic run(input logic [63:0] hdr, input int nh, input int nr, input bit dual);
    logic [7:0] b;
    host_u.open_f();
    for (int i = 0; i < nh; i++) host_u.xfer(hdr[63 - 8 * i -: 8], 1'b0, b);
    for (int i = 0; i < nr; i++) host_u.xfer(8'h00, dual, rx[i]);
    host_u.close_f();
  endtask
  task automatic cmd(input logic [7:0] op);
    run({op, 56'h0}, 1, 0, 1'b0);
  endtask
  // Bounded wait for busy or deep sleep to reach a level
  task automatic wait_for(input bit on_sleep, input logic val);
    int k;
    for (k = 0; k < 20000 && (on_sleep ? sleep : busy) !== val; k++) begin
      @(posedge CLK_IN);
      #1;
    end
    if (k == 20000) begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
    end
  endtask
  task automatic t_ids();
    run({sfce_pkg::OP_STD_ID, 56'h0}, 1, 3, 1'b0);
    chk(rx[0], MFR);
    chk(rx[1], TYP);
    chk(rx[2], CAP);
    run({sfce_pkg::OP_MFR_DEV, 56'h0}, 4, 2, 1'b0);
    chk(rx[0], MFR);
    chk(rx[1], DEV);
    run({sfce_pkg::OP_MFR_DEV, 24'h000001, 32'h0}, 4, 2, 1'b0);
    chk(rx[0], DEV);
    chk(rx[1], MFR);
    run({sfce_pkg::OP_WAKE_ID, 24'ha5a5a5, 32'h0}, 4, 2, 1'b0);
    chk(rx[0], DEV);
    chk(rx[1], DEV);
    run({sfce_pkg::OP_UNIQUE_ID, 32'h5a5a5a5a, 24'h0}, 5, 2, 1'b0);
    chk(rx[0], UID[127:120]);
    chk(rx[1], UID[119:112]);
    $display("t_ids done");
  endtask
  task automatic t_dual();
    run({sfce_pkg::OP_DUAL_READ, 24'h0300fe, 8'h5a, 24'h0}, 5, 2, 1'b1);
    chk(rx[0], 8'hfe ^ 8'h3c);
    chk(rx[1], 8'hff ^ 8'h3c);
    $display("t_dual done");
  endtask
  task automatic t_prog();
    cmd(sfce_pkg::OP_WR_EN);
    chk({7'h00, latch}, 8'h01);
    run({sfce_pkg::OP_PAGE_PROG, 24'h0102fe, 24'h112233, 8'h0}, 7, 0, 1'b0);
    chk({7'h00, busy}, 8'h01);
    chk({7'h00, latch}, 8'h00);
    chk(last_load[15:8], 8'h02);
    chk(last_load[7:0], 8'h00);
    // Clock enable low must freeze the cycle counter past its whole length
    ce = 1'b0;
    repeat (500) @(posedge CLK_IN);
    #1;
    chk({7'h00, busy}, 8'h01);
    ce = 1'b1;
    wait_for(1'b0, 1'b0);
    $display("t_prog done");
  endtask
  task automatic t_erase();
    cmd(sfce_pkg::OP_WR_EN);
    cmd(sfce_pkg::OP_WR_DIS);
    chk({7'h00, latch}, 8'h00);
    run({sfce_pkg::OP_SECT_CLR, 24'h001000, 32'h0}, 4, 0, 1'b0);
    chk({7'h00, busy}, 8'h00);
    cmd(sfce_pkg::OP_WR_EN);
    prot = 3'h7;
    run({sfce_pkg::OP_BLK_CLR, 24'h008000, 32'h0}, 4, 0, 1'b0);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, latch}, 8'h01);
    run({sfce_pkg::OP_PAGE_PROG, 24'h000010, 8'h55, 24'h0}, 5, 0, 1'b0);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, latch}, 8'h01);
    prot = 3'h0;
    run({sfce_pkg::OP_BLK_CLR, 24'h008000, 32'h0}, 4, 0, 1'b0);
    chk({7'h00, busy}, 8'h01);
    seen_oe = 1'b0;
    run({sfce_pkg::OP_STD_ID, 56'h0}, 1, 3, 1'b0);
    run({sfce_pkg::OP_WAKE_ID, 56'h0}, 4, 1, 1'b0);
    chk({7'h00, seen_oe}, 8'h00);
    chk({7'h00, busy}, 8'h01);
    run({sfce_pkg::OP_STATUS_RD, 56'h0}, 1, 1, 1'b0);
    chk(rx[0], 8'h01);
    wait_for(1'b0, 1'b0);
    cmd(sfce_pkg::OP_WR_EN);
    run({sfce_pkg::OP_SECT_CLR, 24'h001000, 32'h0}, 4, 0, 1'b0);
    chk({7'h00, busy}, 8'h01);
    wait_for(1'b0, 1'b0);
    $display("t_erase done");
  endtask
  task automatic t_sleep();
    cmd(sfce_pkg::OP_SLEEP);
    wait_for(1'b1, 1'b1);
    seen_oe = 1'b0;
    run({sfce_pkg::OP_STATUS_RD, 56'h0}, 1, 1, 1'b0);
    chk({7'h00, seen_oe}, 8'h00);
    cmd(sfce_pkg::OP_WAKE_ID);
    wait_for(1'b1, 1'b0);
    run({sfce_pkg::OP_STD_ID, 56'h0}, 1, 1, 1'b0);
    chk(rx[0], MFR);
    cmd(sfce_pkg::OP_SLEEP);
    wait_for(1'b1, 1'b1);
    run({sfce_pkg::OP_WAKE_ID, 56'h0}, 4, 1, 1'b0);
    chk(rx[0], DEV);
    wait_for(1'b1, 1'b0);
    $display("t_sleep done");
  endtask
  // Reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge CLK_IN);
    #1;
    RST_IN = 1'b0;
    t_ids();
    t_dual();
    t_prog();
    t_erase();
    t_sleep();
    results();
  end
endmodule // test_spi_flash_command_engine
